// ### src/vic_defines.svh
`ifndef VIC_DEFINES_SVH
`define VIC_DEFINES_SVH

// ****************************************************************
// Table geometry
// ****************************************************************
`define VIC_NUM_TRAPS      8            // Non-maskable trap vectors
`define VIC_NUM_IRQS       118          // Maskable interrupt sources
`define VIC_NUM_VECS       126          // Traps plus interrupt sources
`define VIC_PRIO_REGS      30           // Priority registers, four fields each
`define VIC_IVT_BASE       24'h000004   // Primary table first entry
`define VIC_ALTERNATE_VECTOR_TABLE_OFFSET    24'h000100   // Alternate table sits after the primary
`define VIC_RESET_ADDR     24'h000000   // Execution start after reset

// ****************************************************************
// Priority fields
// ****************************************************************
`define VIC_PRIO_RST       3'h4         // Field reset value, level 4
`define VIC_PRIO_OFF       3'h0         // Code that disables a source
`define VIC_TRAP_LEVEL     4'h8         // Traps rank above every user level
`define VIC_RTC_REG        15           // Register holding the RTC field
`define VIC_RTC_FIELD      2            // RTC field sits at bits 10-8
`define VIC_ALT_SEL_BIT    15           // Alternate table select position

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define VIC_OFF_CTRL2      12'h000      // interrupt_control_second
`define VIC_OFF_STAT       12'h004      // Sticky event status, write one to clear
`define VIC_OFF_MASK       12'h008      // Event interrupt mask
`define VIC_OFF_STATE      12'h00c      // Live controller state, read only
`define VIC_OFF_PRIO       12'h100      // First priority register
`define VIC_PRIO_MASK      12'hf80      // Window that selects priority space

// ****************************************************************
// Event bits and bus answers
// ****************************************************************
`define VIC_EV_ENTRY       0            // An interrupt entry completed
`define VIC_EV_TRAP        1            // The entry was a trap
`define VIC_EV_RETURN      2            // A return completed
`define VIC_EV_WIDTH       3
`define VIC_RESP_OKAY      2'h0
`define VIC_RESP_SLVERR    2'h2

// ****************************************************************
// Fixed latencies in clock cycles
// ****************************************************************
`define VIC_ENTRY_CYC      4'h5         // Acknowledge to vector address
`define VIC_RET_CYC        4'h3         // Return strobe to return done

`endif

// ### src/vic_pkg.sv
`include "vic_defines.svh"

package vic_pkg;

    // ************************************************************
    // Shared types
    // ************************************************************
    typedef logic [3:0] vic_level_t;    // 0 = nothing, 1..7 user, 8 trap
    typedef logic [6:0] vic_vec_t;      // Vector number, 0..125

    // Controller sequencing
    typedef enum logic [1:0] {
        VIC_ST_IDLE   = 2'b00,
        VIC_ST_ENTRY  = 2'b01,
        VIC_ST_RETURN = 2'b10
    } vic_state_t;

    // AXI4-Lite master to slave
    typedef struct packed {
        logic        awvalid;
        logic [11:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [11:0] araddr;
        logic        rready;
    } vic_axi_req_t;

    // AXI4-Lite slave to master
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } vic_axi_rsp_t;

    // Toward the processor core
    typedef struct packed {
        logic        req;           // Single merged request
        vic_vec_t    vec_num;       // Vector presented with req
        vic_level_t  level;         // Level presented with req
        logic        entry_valid;   // One-cycle: entry_addr is good
        logic [23:0] entry_addr;    // Table word to fetch the routine from
        logic        return_done;   // One-cycle: return finished
    } vic_core_t;

endpackage : vic_pkg

// ### src/vic_arbiter.sv
`timescale 1ns/1ps
`include "vic_defines.svh"

// ****************************************************************
// Winner selection over all vectors
// ****************************************************************
module vic_arbiter (
    input  wire logic [`VIC_NUM_VECS-1:0][3:0] i_levels,
    output logic                               o_valid,
    output vic_pkg::vic_vec_t                  o_vec,
    output vic_pkg::vic_level_t                o_level
);
    import vic_pkg::*;

    vic_level_t best;   // Highest level seen so far
    vic_vec_t   idx;    // Its vector

    // Walk from the top entry down; ">=" lets the lower vector take a tie
    always_comb begin
        best = 4'h0;
        idx  = 7'h00;
        for (int i = `VIC_NUM_VECS - 1; i >= 0; i--) begin
            if ((i_levels[i] != 4'h0) && (i_levels[i] >= best)) begin
                best = i_levels[i];
                idx  = 7'(i);
            end
        end
        o_valid = (best != 4'h0);
        o_vec   = idx;
        o_level = best;
    end

endmodule : vic_arbiter

// ### src/vic_top.sv
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "vic_defines.svh"

// Notes on behaviour
// - Merge all requests into one core request
// - Seven software-set priority levels per source; sources 60, 61 and 63 have no field and never request
// - Eight non-maskable traps, own vectors each
// - Primary table starts at word 000004h
// - 126 entries: 8 traps, 118 interrupts
// - Each entry yields a 24-bit routine address
// - Equal level: lower vector wins; vector 0 first
// - Select bit 15 switches to alternate table
// - Alternate table follows primary, same layout
// - Entry and return latencies fixed
// - Reset bypasses controller, start at 000000h
// - RTC priority bits 10-8, reset 100
// - Unimplemented priority bits read zero
module vic_top (
    input  wire logic                  i_clk,
    input  wire logic                  i_srst,
    input  wire vic_pkg::vic_axi_req_t i_axi,
    output vic_pkg::vic_axi_rsp_t      o_axi,
    input  wire logic [`VIC_NUM_IRQS-1:0]  i_irq,
    input  wire logic [`VIC_NUM_TRAPS-1:0] i_trap,
    input  wire vic_pkg::vic_level_t   i_cpu_ipl,
    input  wire logic                  i_irq_ack,
    input  wire logic                  i_return,
    output vic_pkg::vic_core_t         o_core,
    output logic                       o_int
);
    import vic_pkg::*;

    // ************************************************************
    // Helpers
    // ************************************************************

    // A source has a field unless it shares the RTC register
    function automatic logic src_impl(input int s);
        return (s < `VIC_NUM_IRQS) &&
               !((s / 4 == `VIC_RTC_REG) && (s % 4 != `VIC_RTC_FIELD));
    endfunction : src_impl

    // ************************************************************
    // Storage
    // ************************************************************
    logic [2:0]              prio [`VIC_NUM_IRQS];  // Per-source level
    logic                    alt_sel;               // alternate_table_select
    logic [`VIC_EV_WIDTH-1:0] status;               // Sticky events
    logic [`VIC_EV_WIDTH-1:0] mask;                 // Event enables
    logic [`VIC_EV_WIDTH-1:0] next_status;          // Status after this edge
    logic [`VIC_EV_WIDTH-1:0] events;               // This cycle's events

    // Bus side
    logic        awready_q;     // Address slot free
    logic        wready_q;      // Data slot free
    logic        aw_held;       // Write address captured
    logic        w_held;        // Write data captured
    logic [11:0] aw_addr_q;     // Captured write address
    logic [31:0] w_data_q;      // Captured write data
    logic [3:0]  w_strb_q;      // Captured strobes
    logic        bvalid_q;      // Write answer pending
    logic [1:0]  bresp_q;       // Write answer code
    logic        arready_q;     // Read address slot free
    logic        ar_held;       // Read address captured
    logic [11:0] ar_addr_q;     // Captured read address
    logic        rvalid_q;      // Read answer pending
    logic [31:0] rdata_q;       // Read answer data
    logic [1:0]  rresp_q;       // Read answer code
    logic        do_write;      // Both halves present, apply now

    // Core side
    vic_state_t  state;         // Sequencer state
    logic [3:0]  cnt;           // Latency counter
    logic        req_q;         // Request toward the core
    vic_vec_t    vec_q;         // Vector shown with the request
    vic_level_t  lvl_q;         // Level shown with the request
    vic_vec_t    act_vec;       // Vector being entered
    logic        entry_valid_q; // Entry strobe
    logic [23:0] entry_addr_q;  // Address of the table word
    logic        ret_done_q;    // Return strobe
    logic        int_q;         // Event interrupt line

    // Arbitration
    logic [`VIC_NUM_VECS-1:0][3:0] levels;  // Effective level per vector
    logic        arb_valid;     // Some vector pends
    vic_vec_t    arb_vec;       // Winning vector
    vic_level_t  arb_lvl;       // Winning level

    // ************************************************************
    // Write decode
    // ************************************************************
    logic       wr_ctrl;        // Hits interrupt_control_second
    logic       wr_stat;        // Hits status
    logic       wr_mask;        // Hits mask
    logic       wr_prio;        // Hits a priority register
    logic [4:0] wr_idx;         // Which priority register

    always_comb begin
        do_write = aw_held && w_held && !bvalid_q;
        wr_idx   = aw_addr_q[6:2];
        wr_ctrl  = do_write && (aw_addr_q == `VIC_OFF_CTRL2);
        wr_stat  = do_write && (aw_addr_q == `VIC_OFF_STAT);
        wr_mask  = do_write && (aw_addr_q == `VIC_OFF_MASK);
        wr_prio  = do_write && ((aw_addr_q & `VIC_PRIO_MASK) == `VIC_OFF_PRIO) &&
                   (aw_addr_q[1:0] == 2'h0) && (wr_idx < 5'(`VIC_PRIO_REGS));
    end

    // ************************************************************
    // Per-source priority and effective level
    // ************************************************************
    generate
        for (genvar s = 0; s < `VIC_NUM_IRQS; s++) begin : g_src
            localparam int J = s % 4;   // Field slot in its register
            if (src_impl(s)) begin : g_impl
                // Field write, byte lane by slot; reset level 4
                always_ff @(posedge i_clk) begin
                    if (i_srst) begin
                        prio[s] <= `VIC_PRIO_RST;
                    end else if (wr_prio && (wr_idx == 5'(s / 4)) &&
                                 w_strb_q[J / 2]) begin
                        prio[s] <= w_data_q[4 * J +: 3];
                    end
                end
            end else begin : g_none
                // No field: never requests, reads zero
                assign prio[s] = `VIC_PRIO_OFF;
            end
            // Code 000 disables the source
            assign levels[`VIC_NUM_TRAPS + s] =
                (i_irq[s] && (prio[s] != `VIC_PRIO_OFF)) ? {1'b0, prio[s]} : 4'h0;
        end
        for (genvar t = 0; t < `VIC_NUM_TRAPS; t++) begin : g_trap
            // Traps ignore every priority setting
            assign levels[t] = i_trap[t] ? `VIC_TRAP_LEVEL : 4'h0;
        end
    endgenerate

    // ************************************************************
    // Arbiter
    // ************************************************************
    vic_arbiter u_arb (
        .i_levels (levels),
        .o_valid  (arb_valid),
        .o_vec    (arb_vec),
        .o_level  (arb_lvl)
    );

    // ************************************************************
    // Control and event registers
    // ************************************************************

    // Table select, lane 1 only
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            alt_sel <= 1'b0;
        end else if (wr_ctrl && w_strb_q[1]) begin
            alt_sel <= w_data_q[`VIC_ALT_SEL_BIT];
        end
    end

    // Mask, lane 0
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            mask <= '0;
        end else if (wr_mask && w_strb_q[0]) begin
            mask <= w_data_q[`VIC_EV_WIDTH-1:0];
        end
    end

    // Events of this cycle; a new event beats a same-cycle clear
    always_comb begin
        events = '0;
        events[`VIC_EV_ENTRY]  = (state == VIC_ST_ENTRY) && (cnt == 4'h0);
        events[`VIC_EV_TRAP]   = events[`VIC_EV_ENTRY] &&
                                 (act_vec < 7'(`VIC_NUM_TRAPS));
        events[`VIC_EV_RETURN] = (state == VIC_ST_RETURN) && (cnt == 4'h0);
        next_status = status;
        if (wr_stat && w_strb_q[0]) begin
            next_status = status & ~w_data_q[`VIC_EV_WIDTH-1:0];
        end
        next_status = next_status | events;
    end

    // Sticky status and the level interrupt
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            status <= '0;
            int_q  <= 1'b0;
        end else begin
            status <= next_status;
            int_q  <= |(next_status & mask);
        end
    end

    // ************************************************************
    // Core sequencer
    // ************************************************************

    // One merged request, gated by the core's own level
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state         <= VIC_ST_IDLE;
            cnt           <= 4'h0;
            req_q         <= 1'b0;
            vec_q         <= '0;
            lvl_q         <= '0;
            act_vec       <= '0;
            entry_valid_q <= 1'b0;
            entry_addr_q  <= `VIC_RESET_ADDR;
            ret_done_q    <= 1'b0;
        end else begin
            entry_valid_q <= 1'b0;
            ret_done_q    <= 1'b0;
            case (state)
                VIC_ST_IDLE: begin
                    if (i_irq_ack && req_q) begin
                        // Taken: the load and exit edges add one each, so load two short
                        act_vec <= vec_q;
                        req_q   <= 1'b0;
                        cnt     <= `VIC_ENTRY_CYC - 4'h2;
                        state   <= VIC_ST_ENTRY;
                    end else if (i_return) begin
                        req_q <= 1'b0;
                        cnt   <= `VIC_RET_CYC - 4'h2;
                        state <= VIC_ST_RETURN;
                    end else begin
                        req_q <= arb_valid && (arb_lvl > i_cpu_ipl);
                        vec_q <= arb_vec;
                        lvl_q <= arb_lvl;
                    end
                end
                VIC_ST_ENTRY: begin
                    if (cnt == 4'h0) begin
                        // Word address: base plus two per entry
                        entry_addr_q  <= (alt_sel ? (`VIC_IVT_BASE + `VIC_ALTERNATE_VECTOR_TABLE_OFFSET)
                                                  : `VIC_IVT_BASE)
                                         + {16'h0000, act_vec, 1'b0};
                        entry_valid_q <= 1'b1;
                        state         <= VIC_ST_IDLE;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                VIC_ST_RETURN: begin
                    if (cnt == 4'h0) begin
                        ret_done_q <= 1'b1;
                        state      <= VIC_ST_IDLE;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                default: begin
                    state <= VIC_ST_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // AXI4-Lite write channel
    // ************************************************************

    // Address slot; reopens only after the answer is taken
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            awready_q <= 1'b0;
            aw_held   <= 1'b0;
            aw_addr_q <= '0;
        end else if (i_axi.awvalid && awready_q) begin
            awready_q <= 1'b0;
            aw_held   <= 1'b1;
            aw_addr_q <= i_axi.awaddr;
        end else begin
            if (do_write) begin
                aw_held <= 1'b0;
            end
            awready_q <= !aw_held && !bvalid_q;
        end
    end

    // Data slot, independent of the address slot
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            wready_q <= 1'b0;
            w_held   <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else if (i_axi.wvalid && wready_q) begin
            wready_q <= 1'b0;
            w_held   <= 1'b1;
            w_data_q <= i_axi.wdata;
            w_strb_q <= i_axi.wstrb;
        end else begin
            if (do_write) begin
                w_held <= 1'b0;
            end
            wready_q <= !w_held && !bvalid_q;
        end
    end

    // Answer once both halves are in; unmapped gets SLVERR
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `VIC_RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q  <= (wr_ctrl || wr_stat || wr_mask || wr_prio ||
                         (aw_addr_q == `VIC_OFF_STATE)) ? `VIC_RESP_OKAY
                                                        : `VIC_RESP_SLVERR;
        end else if (bvalid_q && i_axi.bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // ************************************************************
    // AXI4-Lite read channel
    // ************************************************************
    logic [15:0] rd_word;   // Selected register
    logic        rd_hit;    // Address maps to a register
    logic [4:0]  rd_idx;    // Priority register index

    // Read mux; absent fields and upper bits return zero
    always_comb begin
        rd_idx  = ar_addr_q[6:2];
        rd_word = 16'h0000;
        rd_hit  = 1'b1;
        if (ar_addr_q == `VIC_OFF_CTRL2) begin
            rd_word[`VIC_ALT_SEL_BIT] = alt_sel;
        end else if (ar_addr_q == `VIC_OFF_STAT) begin
            rd_word[`VIC_EV_WIDTH-1:0] = status;
        end else if (ar_addr_q == `VIC_OFF_MASK) begin
            rd_word[`VIC_EV_WIDTH-1:0] = mask;
        end else if (ar_addr_q == `VIC_OFF_STATE) begin
            rd_word = {req_q, 1'b0, state, lvl_q, 1'b0, vec_q};
        end else if (((ar_addr_q & `VIC_PRIO_MASK) == `VIC_OFF_PRIO) &&
                     (ar_addr_q[1:0] == 2'h0) && (rd_idx < 5'(`VIC_PRIO_REGS))) begin
            for (int j = 0; j < 4; j++) begin
                if (src_impl(int'(rd_idx) * 4 + j)) begin
                    rd_word[4 * j +: 3] = prio[int'(rd_idx) * 4 + j];
                end
            end
        end else begin
            rd_hit = 1'b0;
        end
    end

    // Address capture and a single-beat answer
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            arready_q <= 1'b0;
            ar_held   <= 1'b0;
            ar_addr_q <= '0;
            rvalid_q  <= 1'b0;
            rdata_q   <= '0;
            rresp_q   <= `VIC_RESP_OKAY;
        end else begin
            if (i_axi.arvalid && arready_q) begin
                arready_q <= 1'b0;
                ar_held   <= 1'b1;
                ar_addr_q <= i_axi.araddr;
            end else if (ar_held) begin
                ar_held  <= 1'b0;
                rvalid_q <= 1'b1;
                rdata_q  <= {16'h0000, rd_word};
                rresp_q  <= rd_hit ? `VIC_RESP_OKAY : `VIC_RESP_SLVERR;
            end else if (rvalid_q && i_axi.rready) begin
                rvalid_q <= 1'b0;
            end else begin
                arready_q <= !rvalid_q;
            end
        end
    end

    // ************************************************************
    // Outputs, all from flops
    // ************************************************************
    assign o_axi.awready    = awready_q;
    assign o_axi.wready     = wready_q;
    assign o_axi.bvalid     = bvalid_q;
    assign o_axi.bresp      = bresp_q;
    assign o_axi.arready    = arready_q;
    assign o_axi.rvalid     = rvalid_q;
    assign o_axi.rdata      = rdata_q;
    assign o_axi.rresp      = rresp_q;
    assign o_core.req         = req_q;
    assign o_core.vec_num     = vec_q;
    assign o_core.level       = lvl_q;
    assign o_core.entry_valid = entry_valid_q;
    assign o_core.entry_addr  = entry_addr_q;
    assign o_core.return_done = ret_done_q;
    assign o_int              = int_q;

endmodule : vic_top

// ### verification/vic_chk.sv
`timescale 1ns/1ps
// ****
// Core side checks
// ****
module vic_chk (
    input wire logic                i_clk,
    input wire logic                i_srst,
    input wire logic [7:0]          i_trap,
    input wire vic_pkg::vic_level_t i_cpu_ipl,
    input wire logic                i_irq_ack,
    input wire logic                i_return,
    input wire vic_pkg::vic_core_t  o_core,
    input wire logic                o_int
);
    import vic_pkg::*;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);
    a_entry_time: assert property (i_irq_ack && o_core.req |-> ##5 o_core.entry_valid)
        else $error("entry late");
    a_offer_drop: assert property (i_irq_ack && o_core.req |=> !o_core.req [*4])
        else $error("offer stayed up");
    a_ret_time: assert property ($rose(o_core.return_done) |-> $past(i_return, 3))
        else $error("return late");
    a_entry_pulse: assert property (o_core.entry_valid |=> !o_core.entry_valid)
        else $error("entry pulse long");
    a_above_ipl: assert property (o_core.req |-> o_core.level > $past(i_cpu_ipl))
        else $error("offer not above core level");
    a_trap_level: assert property (o_core.req |-> (o_core.level == 4'h8) == $past(|i_trap))
        else $error("trap level wrong");
    a_trap_order: assert property (o_core.req && o_core.level == 4'h8 |->
        o_core.vec_num[6:3] == 4'h0 && ($past(i_trap) & ((8'h2 << o_core.vec_num[2:0]) - 8'h1))
        == (8'h1 << o_core.vec_num[2:0])) else $error("trap order wrong");
    a_entry_addr: assert property (o_core.entry_valid |-> o_core.entry_addr[23:9] == 15'h0 &&
        o_core.entry_addr[7:0] == 8'h04 + {$past(o_core.vec_num, 5), 1'b0})
        else $error("entry address wrong");
    a_reset_clear: assert property (disable iff (1'b0) i_srst |=> !o_core.req &&
        !o_core.entry_valid && o_core.entry_addr == 24'h0 && !o_int) else $error("reset state");
    c_entry: cover property (o_core.entry_valid);
    c_ret: cover property (o_core.return_done);
    c_int: cover property (o_int);
endmodule : vic_chk

bind vic_top vic_chk u_chk (.i_clk, .i_srst, .i_trap, .i_cpu_ipl, .i_irq_ack, .i_return,
    .o_core, .o_int);

// ### verification/vic_core_model.sv
`timescale 1ns/1ps
// ****
// Core model: takes offers, returns later
// ****
module vic_core_model (
    input  wire logic               i_clk,
    input  wire logic               i_srst,
    input  wire logic               i_slow,  // Stall each ack
    input  wire vic_pkg::vic_core_t i_core,
    output logic                    o_ack,
    output logic                    o_ret,
    output logic [23:0]             o_addr,  // Last table word
    output logic [7:0]              o_cnt    // Entries seen
);
    import vic_pkg::*;
    logic [2:0] wait_q;  // Cycles the offer has stood
    logic [1:0] ret_q;   // Routine run time
    // One-cycle ack, never beside a return, else that return is lost
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            {wait_q, ret_q, o_ack, o_ret} <= '0;
        end else begin
            wait_q <= i_core.req ? wait_q + 3'h1 : 3'h0;
            o_ack <= i_core.req && !o_ack && !ret_q[1] && (!i_slow || wait_q == 3'h6);
            ret_q <= {ret_q[0], i_core.entry_valid};
            o_ret <= ret_q[1];
        end
    end
    // Record each table fetch
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            {o_addr, o_cnt} <= '0;
        end else if (i_core.entry_valid) begin
            o_addr <= i_core.entry_addr;
            o_cnt <= o_cnt + 8'h1;
        end
    end
endmodule : vic_core_model

// ### verification/test_vectored_interrupt_controller.sv
`timescale 1ns/1ps
module test_vectored_interrupt_controller;
    import vic_pkg::*;
    logic i_clk = 1'b0, i_srst = 1'b1, slow = 1'b0, ack, ret, o_int;
    logic [117:0] irq = '0;
    logic [7:0] trap = '0, cnt;
    logic [23:0] addr;
    vic_level_t ipl = 4'h0;
    vic_axi_req_t ax = '0;
    vic_axi_rsp_t rs;
    vic_core_t core;
    int err_total = 0, n_compared = 0;
    always #20 i_clk = ~i_clk;
    vic_top uut (.i_clk, .i_srst, .i_axi(ax), .o_axi(rs), .i_irq(irq), .i_trap(trap),
        .i_cpu_ipl(ipl), .i_irq_ack(ack), .i_return(ret), .o_core(core), .o_int);
    vic_core_model u_core (.i_clk, .i_srst, .i_slow(slow), .i_core(core), .o_ack(ack),
        .o_ret(ret), .o_addr(addr), .o_cnt(cnt));
    task chk(input logic [31:0] g, input logic [31:0] x);
        n_compared++;
        if (g !== x) begin
            err_total++;
            $display("MISMATCH at %0t: got %h want %h", $time, g, x);
        end
    endtask : chk
    task give_verdict;
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict
    // Bus write, both channels offered together
    task wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] e);
        @(posedge i_clk);
        {ax.awvalid, ax.wvalid, ax.bready, ax.wstrb} <= 7'h7f;
        ax.awaddr <= a;
        ax.wdata <= {16'h0, d};
        do begin
            @(posedge i_clk);
            if (rs.awready) ax.awvalid <= 1'b0;
            if (rs.wready) ax.wvalid <= 1'b0;
        end while (!rs.bvalid);
        ax.bready <= 1'b0;
        chk({30'h0, rs.bresp}, {30'h0, e});
    endtask : wr
    task rd(input logic [11:0] a, input logic [15:0] d, input logic [1:0] e);
        @(posedge i_clk);
        {ax.arvalid, ax.rready} <= 2'h3;
        ax.araddr <= a;
        do begin
            @(posedge i_clk);
            if (rs.arready) ax.arvalid <= 1'b0;
        end while (!rs.rvalid);
        ax.rready <= 1'b0;
        chk(rs.rdata, {16'h0, d});
        chk({30'h0, rs.rresp}, {30'h0, e});
    endtask : rd
    // Raise requests; sources drop once the core acks
    task run(input logic [117:0] q, input logic [7:0] t, input logic [23:0] x, input logic [7:0] k);
        logic [7:0] c;
        int n;
        c = cnt;
        n = 0;
        {irq, trap} <= {q, t};
        while (cnt == c && n < 60) begin
            @(posedge i_clk);
            n++;
            if (ack) {irq, trap} <= '0;
        end
        chk({cnt - c, addr}, {k, x});
        {irq, trap} <= '0;
        @(posedge i_clk);
    endtask : run
    initial begin
        repeat (3) @(posedge i_clk);
        i_srst <= 1'b0;
        rd(12'h13c, 16'h0400, 2'h0);
        rd(12'h010, 16'h0000, 2'h2);
        wr(12'h010, 16'h1234, 2'h2);
        wr(12'h13c, 16'hffff, 2'h0);
        rd(12'h13c, 16'h0700, 2'h0);
        wr(12'h008, 16'h0001, 2'h0);
        run((118'h1 << 62) | 118'h3, 8'h0, 24'h000090, 8'h1);
        repeat (2) @(posedge i_clk);
        chk({31'h0, o_int}, 32'h1);
        wr(12'h004, 16'h0001, 2'h0);
        rd(12'h004, 16'h0004, 2'h0);
        chk({31'h0, o_int}, 32'h0);
        run(118'h3, 8'h0, 24'h000014, 8'h1);
        slow <= 1'b1;
        run(118'h1 << 62, 8'h28, 24'h00000a, 8'h1);
        slow <= 1'b0;
        wr(12'h000, 16'h8000, 2'h0);
        run(118'h0, 8'h01, 24'h000104, 8'h1);
        wr(12'h000, 16'h0000, 2'h0);
        ipl <= 4'h7;
        run(118'h1 << 62, 8'h0, 24'h000104, 8'h0);
        run(118'h0, 8'h80, 24'h000012, 8'h1);
        ipl <= 4'h0;
        wr(12'h13c, 16'h0000, 2'h0);
        run(118'h1 << 62, 8'h0, 24'h000012, 8'h0);
        give_verdict();
    end
    // Watchdog against a hung handshake
    initial begin
        repeat (5000) @(posedge i_clk);
        err_total++;
        give_verdict();
    end
endmodule : test_vectored_interrupt_controller
